// ==== hdl/nfh_host.sv ====
// nfh_host: host controller that drives a byte-wide nand flash by its pins
// assumes the device's ready/busy line is pulled up outside and sampled here
//
// How it works
// - each byte is a write strobe pulse low with select low; rising edge latches.
// - command latch high for commands, address latch high for addresses.
// - four address cycles: column, then row low, middle, high.
// - read and program send four address cycles; erase sends three row cycles.
// - program is 80h, address, data, then 10h to start.
// - dummy planes end with 11h instead of 10h.
// - copy-back is 00h/8ah/10h, or 03h/8ah/11h for dummy planes.
// - erase is 60h plus row per plane, then one d0h.
// - multi-plane results are read with status command 71h.
// - host passes read, status and confirm bytes from req_sub_in unchecked.
// - host never mixes plane groups in one operation.
`default_nettype none
module nfh_host #(
  parameter int unsigned FIFO_DEPTH = nfh_pkg::FIFO_DEPTH
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // request side
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [3:0]  req_op_in,
  input  wire logic [7:0]  req_sub_in,     // read cmd / final confirm byte
  input  wire logic        req_first_in,   // copy: first half (00h) form
  input  wire logic [17:0] req_row_in,
  input  wire logic [9:0]  req_col_in,
  input  wire logic [9:0]  req_len_in,
  // write data stream into fifo
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  // read data stream from fifo
  output logic [7:0]       rdata_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output logic             done_out,
  output logic             busy_out,
  // device pins
  output logic             sel_n_out,
  output logic             cmd_latch_out,
  output logic             addr_latch_out,
  output logic             write_strobe_n_out,
  output logic             read_strobe_n_out,
  output logic             wp_n_out,
  input  wire logic        ready_busy_in,
  input  wire logic [7:0]  io_port_in,
  output logic [7:0]       io_port_out,
  output logic             io_port_oe_out
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_CMD1 = 4'h1, ST_ADDR = 4'h2, ST_WDATA = 4'h3,
    ST_CMD2  = 4'h4, ST_CMD3 = 4'h5, ST_WAIT = 4'h6, ST_RDATA = 4'h7,
    ST_DONE  = 4'h8
  } nfh_state_t;

  nfh_state_t  st_q, st_d;
  logic [3:0]  op_q;
  logic [7:0]  sub_q;
  logic        first_q;
  logic [17:0] row_q;
  logic [7:0]  col_q;
  logic [9:0]  len_q;
  logic [9:0]  cnt_q;
  logic [1:0]  acnt_q;
  logic [3:0]  tcnt_q;
  logic        phase_q;          // 0: strobe low half, 1: high half
  logic [7:0]  io_d;
  logic        act_q;
  logic        cb_q;             // copy: 8ah sent, next ready ends the op
  // fifo taps
  logic [7:0]  wf_data;
  logic        wf_valid;
  logic        wr_pop;
  logic        rf_ready;
  logic [7:0]  rd_byte_q;
  logic        rd_push_q;

  // host-side write data is queued so the pin sequencer can stall on it
  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .wr_data_in(wdata_in), .wr_valid_in(wvalid_in), .wr_ready_out(wready_out),
    .rd_data_out(wf_data), .rd_valid_out(wf_valid),
    .rd_ready_in(wr_pop)
  );
  // read bytes queue toward the user; a full fifo stalls read strobes
  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rfifo (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .wr_data_in(rd_byte_q), .wr_valid_in(rd_push_q), .wr_ready_out(rf_ready),
    .rd_data_out(rdata_out), .rd_valid_out(rvalid_out),
    .rd_ready_in(rready_in)
  );

  // decode of the current operation
  wire op_erase  = (op_q == 4'(nfh_pkg::NFH_OP_ERASE));
  wire op_prog   = (op_q == 4'(nfh_pkg::NFH_OP_PROG));
  wire op_copy   = (op_q == 4'(nfh_pkg::NFH_OP_COPY));
  wire op_read   = (op_q == 4'(nfh_pkg::NFH_OP_READ));
  wire op_id     = (op_q == 4'(nfh_pkg::NFH_OP_READ_ID));
  wire op_status = (op_q == 4'(nfh_pkg::NFH_OP_STATUS));
  wire op_reset  = (op_q == 4'(nfh_pkg::NFH_OP_RESET));
  wire tick      = ce_in && (tcnt_q == nfh_pkg::HALF_CNT - 4'h1);
  wire step      = tick && phase_q;               // end of one byte slot
  wire a_last    = op_erase ? (acnt_q == 2'd2) : (acnt_q == 2'd3);
  wire w_last    = (cnt_q == len_q - 10'd1);
  wire stall_w   = (st_q == ST_WDATA) && !wf_valid && !phase_q;
  // a full user fifo holds the strobe high before the next fall, never
  // after the last byte, so a stalled reader cannot hang the sequence
  wire stall_r   = (st_q == ST_RDATA) && phase_q && !w_last && !rf_ready;
  assign wr_pop  = (st_q == ST_WDATA) && step;
  wire strobe_w  = (st_q == ST_CMD1) || (st_q == ST_ADDR) ||
                   (st_q == ST_WDATA) || (st_q == ST_CMD2) ||
                   (st_q == ST_CMD3);

  // first command byte: read and status pass req_sub_in through unchecked
  logic [7:0] cmd1;
  always_comb begin
    case (op_q)
      4'(nfh_pkg::NFH_OP_READ):    cmd1 = sub_q;
      4'(nfh_pkg::NFH_OP_READ_ID): cmd1 = nfh_pkg::CMD_READ_ID;
      4'(nfh_pkg::NFH_OP_RESET):   cmd1 = nfh_pkg::CMD_RESET;
      4'(nfh_pkg::NFH_OP_PROG):    cmd1 = nfh_pkg::CMD_PROG;
      4'(nfh_pkg::NFH_OP_COPY):    cmd1 = first_q ? nfh_pkg::CMD_READ_A
                                        : nfh_pkg::CMD_CB_DUMMY;
      4'(nfh_pkg::NFH_OP_ERASE):   cmd1 = nfh_pkg::CMD_ERASE;
      4'(nfh_pkg::NFH_OP_STATUS):  cmd1 = sub_q;
      default:                     cmd1 = nfh_pkg::CMD_STATUS;
    endcase
  end
  // address bytes: column, then row low to high
  logic [7:0] abyte;
  always_comb begin
    case (op_erase ? acnt_q + 2'd1 : acnt_q)
      2'd0:    abyte = col_q;
      2'd1:    abyte = row_q[7:0];
      2'd2:    abyte = row_q[15:8];
      default: abyte = {6'h00, row_q[17:16]};
    endcase
  end

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (req_valid_in && ce_in) st_d = ST_CMD1;
      ST_CMD1:  if (step) begin
        if (op_reset) st_d = ST_WAIT;
        else if (op_status || op_id) st_d = op_id ? ST_ADDR : ST_RDATA;
        else st_d = ST_ADDR;
      end
      ST_ADDR:  if (step && (op_id || a_last)) begin
        if (op_prog) st_d = ST_WDATA;
        else if (op_erase) st_d = ST_CMD2;
        else if (op_id) st_d = ST_RDATA;
        else st_d = ST_WAIT;
      end
      ST_WDATA: if (step && w_last) st_d = ST_CMD2;
      ST_CMD2:  if (step) st_d = op_copy ? ST_CMD3 : ST_WAIT;
      ST_CMD3:  if (step) st_d = ST_WAIT;
      // copy reads its source first; 8ah is only sent once ready again
      ST_WAIT:  if (ce_in && ready_busy_in && tcnt_q == 4'hf)
                  st_d = op_read ? ST_RDATA
                       : (op_copy && !cb_q) ? ST_CMD2 : ST_DONE;
      ST_RDATA: if (step && w_last) st_d = ST_DONE;
      ST_DONE:  st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  // second and third command bytes
  wire [7:0] cmd2 = op_copy ? nfh_pkg::CMD_CB_PROG : sub_q;
  wire [7:0] cmd3 = sub_q;

  // pin drive: write strobe low in first half of each write slot
  assign sel_n_out          = !act_q;
  assign cmd_latch_out      = (st_q == ST_CMD1) || (st_q == ST_CMD2) ||
                              (st_q == ST_CMD3);
  assign addr_latch_out     = (st_q == ST_ADDR);
  assign write_strobe_n_out = !(strobe_w && !phase_q);
  assign read_strobe_n_out  = !((st_q == ST_RDATA) && !phase_q);
  assign wp_n_out           = act_q && (op_prog || op_copy || op_erase);
  assign io_port_out        = io_d;  // decoded: stands the whole slot
  assign io_port_oe_out     = strobe_w;
  assign req_ready_out      = (st_q == ST_IDLE);
  assign busy_out           = (st_q != ST_IDLE);
  assign done_out           = (st_q == ST_DONE);

  // output byte for the slot in progress; a register here would lag the
  // falling strobe by a cycle and show the previous byte with latch high
  always_comb begin
    case (st_q)
      ST_CMD1:  io_d = cmd1;
      ST_ADDR:  io_d = abyte;
      ST_WDATA: io_d = wf_data;
      ST_CMD2:  io_d = cmd2;
      ST_CMD3:  io_d = cmd3;
      default:  io_d = 8'h00;
    endcase
  end

  // request capture and select
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_q <= 4'h0; sub_q <= 8'h00; first_q <= 1'b0;
      row_q <= 18'h00000; col_q <= 8'h00; len_q <= 10'h001;
      act_q <= 1'b0; cb_q <= 1'b0;
    end else if (ce_in && st_q == ST_IDLE && req_valid_in) begin
      op_q <= req_op_in; sub_q <= req_sub_in; first_q <= req_first_in;
      // one row per request: a single plane, so groups never mix
      row_q <= req_row_in; col_q <= req_col_in[7:0];
      len_q <= (req_len_in == 10'h000) ? 10'h001 : req_len_in;
      act_q <= 1'b1; cb_q <= 1'b0;
    end else if (ce_in && st_q == ST_CMD2) cb_q <= 1'b1;
    else if (ce_in && st_q == ST_DONE) act_q <= 1'b0;
  end

  // sequencing counters
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= ST_IDLE; tcnt_q <= 4'h0; phase_q <= 1'b0;
      acnt_q <= 2'd0; cnt_q <= 10'h000;
      rd_byte_q <= 8'h00; rd_push_q <= 1'b0;
    end else if (ce_in) begin
      st_q      <= st_d;
      rd_push_q <= (st_q == ST_RDATA) && tick && !phase_q;
      if (st_q == ST_RDATA && tick && !phase_q) rd_byte_q <= io_port_in;
      if (st_d != st_q) begin
        tcnt_q <= 4'h0; phase_q <= 1'b0; acnt_q <= 2'd0; cnt_q <= 10'h000;
      end else if (st_q == ST_WAIT) begin
        if (tcnt_q != 4'hf) tcnt_q <= tcnt_q + 4'h1;
      end else if (!stall_w && !stall_r) begin
        tcnt_q <= tick ? 4'h0 : tcnt_q + 4'h1;
        if (tick) phase_q <= !phase_q;
        if (step) begin
          acnt_q <= acnt_q + 2'd1;
          cnt_q  <= cnt_q + 10'h001;
        end
      end
    end
  end
endmodule // nfh_host
`default_nettype wire

// ==== common/nfh_pkg.sv ====
// nfh_pkg: constants shared by the nand flash host controller
// assumes a byte-wide nand device with multiplexed command/address/data port
`default_nettype none
package nfh_pkg;
  // organisation
  localparam int unsigned PAGES       = 262144;
  localparam int unsigned PAGE_BYTES  = 528;
  localparam int unsigned SPARE_START = 512;
  localparam int unsigned BLOCKS      = 8192;
  localparam int unsigned PLANES      = 8;
  // command bytes
  localparam logic [7:0] CMD_READ_A   = 8'h00;
  localparam logic [7:0] CMD_READ_B   = 8'h01;
  localparam logic [7:0] CMD_READ_C   = 8'h50;
  localparam logic [7:0] CMD_READ_ID  = 8'h90;
  localparam logic [7:0] CMD_RESET    = 8'hff;
  localparam logic [7:0] CMD_PROG     = 8'h80;
  localparam logic [7:0] CMD_CONFIRM  = 8'h10;
  localparam logic [7:0] CMD_DUMMY    = 8'h11;
  localparam logic [7:0] CMD_CB_DUMMY = 8'h03;
  localparam logic [7:0] CMD_CB_PROG  = 8'h8a;
  localparam logic [7:0] CMD_ERASE    = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_STATUS_M = 8'h71;
  // host operation codes
  typedef enum logic [3:0] {
    NFH_OP_READ    = 4'h0,
    NFH_OP_READ_ID = 4'h1,
    NFH_OP_RESET   = 4'h2,
    NFH_OP_PROG    = 4'h3,
    NFH_OP_COPY    = 4'h4,
    NFH_OP_ERASE   = 4'h5,
    NFH_OP_STATUS  = 4'h6
  } nfh_op_t;
  // strobe timing: each strobe half lasts this many clocks
  localparam int unsigned T_HALF_NS   = 30;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned HALF_CYC    = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  HALF_CNT    = 4'(HALF_CYC);
  localparam int unsigned FIFO_DEPTH  = 16;
endpackage
`default_nettype wire

// ==== hdl/nfh_fifo.sv ====
// nfh_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock; width and depth are parameters, depth a power of two
`default_nettype none
module nfh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              full  = (wp_q[AW] != rp_q[AW]) &&
                            (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire              empty = (wp_q == rp_q);
  wire              push  = ce_in && wr_valid_in && !full;
  wire              pop   = ce_in && rd_ready_in && !empty;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem_q[rp_q[AW-1:0]];
  // storage has no reset so it can map to ram
  always_ff @(posedge mclk_in) begin
    if (push) mem_q[wp_q[AW-1:0]] <= wr_data_in;
  end
  // pointers carry one extra bit to tell full from empty
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
    end
  end
endmodule // nfh_fifo
`default_nettype wire

// ==== bench/nfh_host_properties.sv ====
// nfh_host_properties: pin-level checks on the nand host controller
// assumes one clock domain and the host's own port names
`default_nettype none
module nfh_host_check (
  input wire logic       mclk_in,
  input wire logic       rst_b_in,
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire logic       sel_n_out,
  input wire logic       cmd_latch_out,
  input wire logic       addr_latch_out,
  input wire logic       write_strobe_n_out,
  input wire logic       read_strobe_n_out,
  input wire logic       wp_n_out,
  input wire logic       ready_busy_in,
  input wire logic [7:0] io_port_out,
  input wire logic       io_port_oe_out,
  input wire logic       wready_out,
  input wire logic       rvalid_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // pin levels and strobe slot widths
  reset_pins_a: assert property (
    $rose(rst_b_in) |-> sel_n_out && !wp_n_out && !io_port_oe_out)
    else $error("pins not idle after reset");
  wr_low_len_a: assert property (
    $fell(write_strobe_n_out) |-> !write_strobe_n_out[*3] ##1 write_strobe_n_out)
    else $error("write strobe low time wrong");
  wr_high_len_a: assert property (
    $rose(write_strobe_n_out) |-> write_strobe_n_out[*3])
    else $error("write strobe high time short");
  rd_low_len_a: assert property (
    $fell(read_strobe_n_out) |-> !read_strobe_n_out[*3] ##1 read_strobe_n_out)
    else $error("read strobe low time wrong");
  strobe_sel_a: assert property (
    !(write_strobe_n_out && read_strobe_n_out) |-> !sel_n_out)
    else $error("strobe without select");
  latch_excl_a: assert property (
    !write_strobe_n_out |-> !(cmd_latch_out && addr_latch_out))
    else $error("both latches high");
  // an undefined command byte could trigger test modes in the part
  cmd_legal_a: assert property (
    cmd_latch_out && !write_strobe_n_out |-> io_port_out inside {8'h00,
      8'h01, 8'h50, 8'h90, 8'hff, 8'h80, 8'h10, 8'h11, 8'h03, 8'h8a,
      8'h60, 8'hd0, 8'h70, 8'h71})
    else $error("illegal command byte");
  drive_dir_a: assert property (
    !read_strobe_n_out |-> !io_port_oe_out && write_strobe_n_out)
    else $error("host drives port while reading");
  wr_drive_a: assert property (
    !write_strobe_n_out |-> io_port_oe_out)
    else $error("port not driven in write slot");
  busy_sel_a: assert property (
    !ready_busy_in |-> !sel_n_out)
    else $error("select dropped while busy");
  wp_idle_a: assert property (
    !busy_out |-> !wp_n_out)
    else $error("write protect open when idle");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  cov_busy_c: cover property ($fell(ready_busy_in));
  cov_full_c: cover property (!wready_out);
  cov_rdata_c: cover property (rvalid_out && done_out);
endmodule // nfh_host_check
bind nfh_host nfh_host_check u_nfh_host_check (.mclk_in, .rst_b_in,
  .busy_out, .done_out, .sel_n_out, .cmd_latch_out, .addr_latch_out,
  .write_strobe_n_out, .read_strobe_n_out, .wp_n_out, .ready_busy_in,
  .io_port_out, .io_port_oe_out, .wready_out, .rvalid_out);
`default_nettype wire

// ==== bench/nfh_flash_model.sv ====
// nfh_flash_model: behavioural byte-wide nand device
// assumes the bench resolves the shared port; mclk_in only times busy
`default_nettype none
module nfh_flash_model #(
  parameter int         BUSY    = 20,
  parameter logic [7:0] ID_BYTE = 8'h5a // arbitrary value
) (
  input  wire logic       mclk_in,
  input  wire logic       sel_n_in,
  input  wire logic       cmd_latch_in,
  input  wire logic       addr_latch_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       read_strobe_n_in,
  input  wire logic       wp_n_in,
  input  wire logic [7:0] io_port_in,
  output logic      [7:0] io_port_out,
  output logic            ready_busy_out
);
  logic [7:0] mem [int];
  logic [7:0] preg [528];
  logic [7:0] cmds [$];
  logic [7:0] a [4];
  logic [7:0] cmd = 8'h00, dout = 8'h00;
  logic       half = 0;
  int         na = 0, nadr = 0, col = 0, rw = 0, bcnt = 0;
  // byte capture on the rising write strobe
  always @(posedge write_strobe_n_in) if (!sel_n_in) begin
    if (cmd_latch_in) begin
      if (bcnt == 0 || io_port_in inside {8'hff, 8'h70, 8'h71}) begin
        cmd = io_port_in;
        cmds.push_back(cmd);
        na = 0;
        if (cmd == 8'h00 || cmd == 8'h01) half = cmd[0];
        if (cmd == 8'h80) foreach (preg[c]) preg[c] = 8'hff;
        // erase clears a whole 32-page block, never less
        if (cmd == 8'hd0 && wp_n_in) begin
          for (int p = 0; p < 32 * 528; p++) mem.delete((rw & ~31) * 528 + p);
          bcnt = BUSY;
        end
        // dummy confirm only queues the page
        // a full-voltage part: copy and dummy planes are honoured
        if ((cmd == 8'h10 || cmd == 8'h11) && wp_n_in) begin
          if (cmd == 8'h10) foreach (preg[c]) mem[rw * 528 + c] = preg[c];
          bcnt = BUSY;
        end
      end
    end else if (addr_latch_in) begin
      if (na < 4) a[na] = io_port_in;
      na++;
      nadr++;
      rw = cmd == 8'h60 ? {a[2], a[1], a[0]} & 18'h3ffff : {a[3], a[2], a[1]};
      col = cmd == 8'h50 ? 512 + a[0][3:0] : half * 256 + a[0];
      if (na == 4 && cmd inside {8'h00, 8'h01, 8'h50, 8'h03}) begin
        foreach (preg[c]) preg[c] = mem.exists(rw * 528 + c) ? mem[rw * 528 + c] : 8'hff;
        bcnt = BUSY;
      end
    end else if (col < 528) begin
      preg[col] = io_port_in;
      col++;
    end
  end
  // each read strobe fall gives the next byte; pointer returns to first half
  always @(negedge read_strobe_n_in) if (!sel_n_in) begin
    dout = cmd inside {8'h70, 8'h71} ? 8'hc0 : cmd == 8'h90 ? ID_BYTE : preg[col];
    col++;
    half = 0;
  end
  // released port shows the inverse so stale values never pass
  assign io_port_out = !sel_n_in && !read_strobe_n_in ? dout : ~dout;
  assign ready_busy_out = bcnt == 0;
  always @(posedge mclk_in) if (bcnt != 0) bcnt = bcnt - 1;
endmodule // nfh_flash_model
`default_nettype wire

// ==== bench/test_nfh_host.sv ====
// test_nfh_host: self-checking bench for the nand host controller
// assumes nfh_flash_model on the pins and host ports named as below
`default_nettype none
module test_nfh_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, rst_b_in = 0, ce_in = 1, req_valid_in = 0;
  logic req_first_in = 0, wvalid_in = 0, rready_in = 0;
  logic [3:0] req_op_in = 0;
  logic [7:0] req_sub_in = 0, wdata_in = 0;
  logic [17:0] req_row_in = 0;
  logic [9:0] req_col_in = 0, req_len_in = 0;
  wire logic req_ready_out, wready_out, rvalid_out, done_out, busy_out;
  wire logic sel_n_out, cmd_latch_out, addr_latch_out, wp_n_out;
  wire logic write_strobe_n_out, read_strobe_n_out, io_port_oe_out;
  wire logic ready_busy_in;
  wire logic [7:0] rdata_out, io_port_out, io_port_in, dev_io;
  int n_errors = 0, n_tests = 0, cyc = 0;
  initial forever #5 mclk_in = ~mclk_in;
  nfh_host u_nfh_host (.*);
  // the port level comes from whoever drives it
  assign io_port_in = io_port_oe_out ? io_port_out : dev_io;
  nfh_flash_model u_nfh_flash_model (.mclk_in, .sel_n_in(sel_n_out),
    .cmd_latch_in(cmd_latch_out), .addr_latch_in(addr_latch_out),
    .write_strobe_n_in(write_strobe_n_out),
    .read_strobe_n_in(read_strobe_n_out), .wp_n_in(wp_n_out),
    .io_port_in, .io_port_out(dev_io), .ready_busy_out(ready_busy_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [7:0] b);
    @(negedge mclk_in);
    wdata_in = b;
    wvalid_in = 1;
    while (wready_out !== 1) @(negedge mclk_in);
    @(negedge mclk_in);
    wvalid_in = 0;
  endtask
  task automatic pop(input logic [7:0] exp);
    @(negedge mclk_in);
    while (rvalid_out !== 1) @(negedge mclk_in);
    check(rdata_out, exp);
    rready_in = 1;
    @(negedge mclk_in);
    rready_in = 0;
  endtask
  // one host operation, returns after done
  task automatic op(input logic [3:0] o, input logic [7:0] s,
                    input logic f, input logic [17:0] r, input logic [9:0] n);
    @(negedge mclk_in);
    {req_op_in, req_sub_in, req_first_in, req_row_in} = {o, s, f, r};
    req_len_in = n;
    req_valid_in = 1;
    while (req_ready_out !== 1) @(negedge mclk_in);
    @(negedge mclk_in);
    req_valid_in = 0;
    while (done_out !== 1) @(negedge mclk_in);
    check(ready_busy_in, 1);
    check(busy_out, 1);
  endtask
  // fill the write buffer until it refuses, then program a page
  task automatic t_prog;
    for (int i = 0; i < 16; i++) push(8'(8'h30 + i));
    @(negedge mclk_in);
    check(wready_out, 0);
    op(nfh_pkg::NFH_OP_PROG, nfh_pkg::CMD_CONFIRM, 0, 5, 16);
    for (int i = 0; i < 16; i++)
      check(u_nfh_flash_model.mem[5 * 528 + i], 8'h30 + i);
  endtask
  // read back with the far side stalled until the op ends
  task automatic t_read;
    rready_in = 0;
    op(nfh_pkg::NFH_OP_READ, nfh_pkg::CMD_READ_A, 0, 5, 16);
    check(rvalid_out, 1);
    for (int i = 0; i < 16; i++) pop(8'(8'h30 + i));
    check(rvalid_out, 0);
  endtask
  // each command form but program with 10h (t_prog has that), with its first and last command and, except copy and id, address count
  task automatic t_cmds;
    logic [3:0] o [11] = '{0, 0, 0, 6, 6, 2, 3, 4, 4, 5, 1};
    logic [7:0] s [11] = '{8'h00, 8'h01, 8'h50, 8'h70, 8'h71, 8'h00,
                           8'h11, 8'h10, 8'h11, 8'hd0, 8'h00};
    logic [7:0] f [11] = '{8'h00, 8'h01, 8'h50, 8'h70, 8'h71, 8'hff,
                           8'h80, 8'h00, 8'h03, 8'h60, 8'h90};
    logic [7:0] l [11] = '{8'h00, 8'h01, 8'h50, 8'h70, 8'h71, 8'hff,
                           8'h11, 8'h10, 8'h11, 8'hd0, 8'h90};
    int na [11] = '{4, 4, 4, 0, 0, 0, 4, -1, -1, 3, -1};
    rready_in = 1;
    for (int i = 0; i < 11; i++) begin
      if (o[i] == 3) push(8'h77);
      u_nfh_flash_model.cmds.delete();
      u_nfh_flash_model.nadr = 0;
      op(o[i], s[i], i == 7, 9, 1);
      check(u_nfh_flash_model.cmds[0], f[i]);
      check(u_nfh_flash_model.cmds[$], l[i]);
      if (na[i] >= 0) check(u_nfh_flash_model.nadr, na[i]);
    end
    rready_in = 0;
  endtask
  // the block erase above covered row 5 as well
  task automatic t_erase;
    op(nfh_pkg::NFH_OP_READ, nfh_pkg::CMD_READ_A, 0, 5, 2);
    pop(8'hff);
    pop(8'hff);
  endtask
  // with the clock enable low a waiting request must start nothing
  task automatic t_hold;
    @(negedge mclk_in);
    ce_in = 0;
    req_valid_in = 1;
    repeat (4) @(negedge mclk_in);
    check(busy_out, 0);
    check(sel_n_out, 1);
    req_valid_in = 0;
    ce_in = 1;
  endtask
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang is cut short and counted as a mismatch
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (6) @(negedge mclk_in);
    rst_b_in = 1;
    t_prog();
    t_read();
    t_cmds();
    t_erase();
    t_hold();
    results();
  end
endmodule // test_nfh_host
`default_nettype wire
